// ### uig_pkg.sv
// Purpose: Shared constants and carrier types for the interrupt gating block.
// Assumes: One controller clock; 32-bit register port with byte addresses.
// Notes: Printed offsets are word aligned, so they serve as byte addresses.
package uig_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned EP_NUM = 6;
  localparam int unsigned EVT_NUM = 7;
  localparam int unsigned TOP_NUM = 8;
  localparam int unsigned SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [31:0] TOP_IRQ_OFS = 32'hb000_6000;
  localparam logic [31:0] TOP_IRQ_ENABLE_OFS = 32'hb000_6008;
  localparam logic [31:0] BUS_EVENT_STATUS_OFS = 32'hb000_6010;
  localparam logic [31:0] BUS_EVENT_ENABLE_OFS = 32'hb000_6014;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [7:0] TOP_IRQ_ENABLE_RST = 8'h01;
  localparam logic [6:0] BUS_EVENT_ENABLE_RST = 7'h40;
  localparam logic [6:0] BUS_EVENT_STATUS_RST = 7'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int unsigned TOP_BUS_EVT_BIT = 0;
  localparam int unsigned TOP_CTRL_EP_BIT = 1;
  localparam int unsigned TOP_EP_LO_BIT = 2;
  localparam int unsigned CLK_USABLE_BIT = 6;
  localparam int unsigned DMA_DONE_BIT = 5;
  localparam int unsigned HS_SETTLED_BIT = 4;
  localparam int unsigned SUSPEND_BIT = 3;
  localparam int unsigned RESUME_BIT = 2;
  localparam int unsigned PORT_RESET_END_BIT = 1;
  localparam int unsigned FRAME_START_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uig_bus_req_t;

  typedef struct packed {
    logic dma_done;
    logic hs_settled;
    logic suspend;
    logic resume;
    logic port_reset_end;
    logic frame_start;
  } uig_evt_t;

endpackage

// ### uig_sync_rise.sv
// Purpose: Two-stage synchroniser with a rising-edge pulse behind it.
// Assumes: The input level is asynchronous to i_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module uig_sync_rise (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_level,
  output logic o_rise
);

  typedef struct packed {
    logic [uig_pkg::SYNC_STAGES-1:0] sync;
    logic prev;
    logic rise;
  } uig_sync_state_t;

  uig_sync_state_t state_r;
  uig_sync_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Shift the level in and mark its rising edge.
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.sync = {state_r.sync[0], i_level};
    state_nxt.prev = state_r.sync[1];
    state_nxt.rise = state_r.sync[1] & ~state_r.prev;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign o_rise = state_r.rise;

endmodule

// ### uig_flag_bank.sv
// Purpose: Bank of sticky flags that hardware sets and software clears.
// Assumes: Set and clear vectors come from logic on i_clk.
// Notes: A set in the same cycle as a clear keeps the flag set.
`timescale 1ns/100ps
module uig_flag_bank #(
  parameter int unsigned N = 7,
  parameter logic [N-1:0] RST = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [N-1:0] i_set,
  input wire logic [N-1:0] i_clr,
  output logic [N-1:0] o_flags
);

  typedef struct packed {
    logic [N-1:0] flag;
  } uig_flag_state_t;

  uig_flag_state_t state_r;
  uig_flag_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Each bit sets on its event and clears on a written one.
  always_comb
  begin
    state_nxt = state_r;
    for (int k = 0; k < N; k++)
    begin
      state_nxt.flag[k] = i_set[k] | (state_r.flag[k] & ~i_clr[k]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r.flag <= RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign o_flags = state_r.flag;

endmodule

// ### uig_irq_gate.sv
// Purpose: Interrupt gating for a USB device controller.
// Assumes: Endpoint pending levels and bus event pulses come from logic on i_clk.
// Notes: The usable-clock level comes from the transceiver and is synchronised.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module uig_irq_gate (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire uig_pkg::uig_bus_req_t i_bus,
  input wire logic [uig_pkg::EP_NUM-1:0] i_ep_pend,
  input wire logic i_ctrl_ep_pend,
  input wire logic i_clk_usable,
  input wire uig_pkg::uig_evt_t i_evt,
  output logic [uig_pkg::DATA_W-1:0] o_rdata,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic [uig_pkg::TOP_NUM-1:0] top_en;
    logic [uig_pkg::EVT_NUM-1:0] evt_en;
    logic irq;
    logic [uig_pkg::DATA_W-1:0] rdata;
  } uig_gate_state_t;

  uig_gate_state_t state_r;
  uig_gate_state_t state_nxt;

  logic clk_rise;
  logic [uig_pkg::EVT_NUM-1:0] evt_set;
  logic [uig_pkg::EVT_NUM-1:0] evt_clr;
  logic [uig_pkg::EVT_NUM-1:0] evt_stat;
  logic bus_pend;
  logic [uig_pkg::TOP_NUM-1:0] top_pend;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by reads and writes.
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] ofs);
    hit = (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Usable-clock edge from the transceiver.
  uig_sync_rise u_clk_ok (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_level(i_clk_usable),
    .o_rise(clk_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event sources and write-one-to-clear.
  always_comb
  begin
    evt_set = '0;
    evt_set[uig_pkg::CLK_USABLE_BIT] = clk_rise;
    evt_set[uig_pkg::DMA_DONE_BIT] = i_evt.dma_done;
    evt_set[uig_pkg::HS_SETTLED_BIT] = i_evt.hs_settled;
    evt_set[uig_pkg::SUSPEND_BIT] = i_evt.suspend;
    evt_set[uig_pkg::RESUME_BIT] = i_evt.resume;
    evt_set[uig_pkg::PORT_RESET_END_BIT] = i_evt.port_reset_end;
    evt_set[uig_pkg::FRAME_START_BIT] = i_evt.frame_start;
    evt_clr = '0;
    if (i_bus.wr && hit(i_bus.addr, uig_pkg::BUS_EVENT_STATUS_OFS))
    begin
      evt_clr = i_bus.wdata[uig_pkg::EVT_NUM-1:0];
    end
  end

  uig_flag_bank #(
    .N(uig_pkg::EVT_NUM),
    .RST(uig_pkg::BUS_EVENT_STATUS_RST)
  ) u_status (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_set(evt_set),
    .i_clr(evt_clr),
    .o_flags(evt_stat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pending sources.
  always_comb
  begin
    bus_pend = |(evt_stat & state_r.evt_en);
    top_pend = {i_ep_pend, i_ctrl_ep_pend, bus_pend};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, read answer and interrupt.
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.irq = |(top_pend & state_r.top_en);
    if (i_bus.wr && hit(i_bus.addr, uig_pkg::TOP_IRQ_ENABLE_OFS))
    begin
      state_nxt.top_en = i_bus.wdata[uig_pkg::TOP_NUM-1:0];
    end
    if (i_bus.wr && hit(i_bus.addr, uig_pkg::BUS_EVENT_ENABLE_OFS))
    begin
      state_nxt.evt_en = i_bus.wdata[uig_pkg::EVT_NUM-1:0];
    end
    state_nxt.rdata = '0;
    if (i_bus.rd)
    begin
      case (1'b1)
        hit(i_bus.addr, uig_pkg::TOP_IRQ_OFS):
        begin
          state_nxt.rdata = {24'h00_0000, top_pend};
        end
        hit(i_bus.addr, uig_pkg::TOP_IRQ_ENABLE_OFS):
        begin
          state_nxt.rdata = {24'h00_0000, state_r.top_en};
        end
        hit(i_bus.addr, uig_pkg::BUS_EVENT_STATUS_OFS):
        begin
          state_nxt.rdata = {25'h000_0000, evt_stat};
        end
        hit(i_bus.addr, uig_pkg::BUS_EVENT_ENABLE_OFS):
        begin
          state_nxt.rdata = {25'h000_0000, state_r.evt_en};
        end
        default:
        begin
          state_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r.top_en <= uig_pkg::TOP_IRQ_ENABLE_RST;
      state_r.evt_en <= uig_pkg::BUS_EVENT_ENABLE_RST;
      state_r.irq <= 1'b0;
      state_r.rdata <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign o_rdata = state_r.rdata;
  assign o_irq = state_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic seen_r;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      seen_r <= 1'b0;
    end
    else
    begin
      seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (!i_rst_n);

  a_ep_gate_open: assert property (
    (|(i_ep_pend & state_r.top_en[7:2])) |=> o_irq
  ) else $error("Enabled pending endpoint did not raise the interrupt.");

  a_ctrl_gate_open: assert property (
    (i_ctrl_ep_pend && state_r.top_en[uig_pkg::TOP_CTRL_EP_BIT]) |=> o_irq
  ) else $error("Enabled control endpoint did not raise the interrupt.");

  a_bus_gate_open: assert property (
    (|(evt_stat & state_r.evt_en) && state_r.top_en[uig_pkg::TOP_BUS_EVT_BIT]) |=> o_irq
  ) else $error("Enabled bus event did not raise the interrupt.");

  a_reset_enables: assert property (
    !seen_r |-> (state_r.top_en == 8'h01 && state_r.evt_en == 7'h40)
  ) else $error("Enable registers wrong after reset.");

  a_suspend_reset: assert property (
    !seen_r |-> (evt_stat == 7'h08)
  ) else $error("Suspend flag not set after reset.");

  a_clk_ok_flag: assert property (
    $rose(i_clk_usable) ##1 1'b1 |-> ##[1:3] evt_stat[6]
  ) else $error("Usable-clock flag did not set.");

  a_dma_flag: assert property (
    i_evt.dma_done |=> evt_stat[uig_pkg::DMA_DONE_BIT]
  ) else $error("DMA completion flag did not set.");

  a_hs_flag: assert property (
    i_evt.hs_settled |=> evt_stat[uig_pkg::HS_SETTLED_BIT]
  ) else $error("High-speed settle flag did not set.");

  a_suspend_flag: assert property (
    i_evt.suspend |=> evt_stat[uig_pkg::SUSPEND_BIT]
  ) else $error("Suspend flag did not set.");

  a_resume_flag: assert property (
    i_evt.resume |=> evt_stat[uig_pkg::RESUME_BIT]
  ) else $error("Resume flag did not set.");

  a_port_reset_flag: assert property (
    i_evt.port_reset_end |=> evt_stat[uig_pkg::PORT_RESET_END_BIT]
  ) else $error("Port reset end flag did not set.");

  a_sof_flag: assert property (
    i_evt.frame_start |=> evt_stat[uig_pkg::FRAME_START_BIT]
  ) else $error("Start-of-frame flag did not set.");

  a_w1c_clear: assert property (
    seen_r |-> ((evt_stat & $past(evt_clr & ~evt_set)) == 7'h00)
  ) else $error("Written one did not clear a status bit.");

  a_w1c_keep: assert property (
    seen_r |-> ((evt_stat & $past(evt_stat & ~evt_clr)) == $past(evt_stat & ~evt_clr))
  ) else $error("Status bit lost without a written one.");

  a_evt_en_write: assert property (
    (i_bus.wr && i_bus.addr == uig_pkg::BUS_EVENT_ENABLE_OFS)
      |=> state_r.evt_en == $past(i_bus.wdata[6:0])
  ) else $error("Event enable write not stored.");

  a_evt_gate_own: assert property (
    ((evt_stat & state_r.evt_en) == 7'h00 && state_r.top_en == 8'h01) |=> !o_irq
  ) else $error("Masked bus event raised the interrupt.");

  a_top_read: assert property (
    (i_bus.rd && i_bus.addr == uig_pkg::TOP_IRQ_OFS)
      |=> o_rdata == {24'h00_0000, $past(top_pend)}
  ) else $error("Top register read shows wrong pending state.");

  a_irq_or: assert property (
    seen_r |-> o_irq == $past(|(top_pend & state_r.top_en))
  ) else $error("Interrupt differs from OR of pending and enabled.");

  a_ten_write: assert property (
    (i_bus.wr && i_bus.addr == uig_pkg::TOP_IRQ_ENABLE_OFS)
      |=> state_r.top_en == $past(i_bus.wdata[7:0])
  ) else $error("Top enable write not stored.");

  a_ten_read: assert property (
    (i_bus.rd && i_bus.addr == uig_pkg::TOP_IRQ_ENABLE_OFS)
      |=> o_rdata == {24'h00_0000, $past(state_r.top_en)}
  ) else $error("Top enable read shows wrong value.");

  a_stat_read: assert property (
    (i_bus.rd && i_bus.addr == uig_pkg::BUS_EVENT_STATUS_OFS)
      |=> o_rdata == {25'h000_0000, $past(evt_stat)}
  ) else $error("Event status read shows wrong value.");

  a_en_read: assert property (
    (i_bus.rd && i_bus.addr == uig_pkg::BUS_EVENT_ENABLE_OFS)
      |=> o_rdata == {25'h000_0000, $past(state_r.evt_en)}
  ) else $error("Event enable read shows wrong value.");

  a_rdata_idle: assert property (
    !i_bus.rd |=> o_rdata == 32'h0000_0000
  ) else $error("Read data stood outside its answer cycle.");

  a_top_ro: assert property (
    (i_bus.wr && i_bus.addr == uig_pkg::TOP_IRQ_OFS)
      |=> state_r.top_en == $past(state_r.top_en) && state_r.evt_en == $past(state_r.evt_en)
  ) else $error("Write to the read-only top register changed an enable.");

  a_irq_quiet: assert property (
    ((top_pend & state_r.top_en) == 8'h00) |=> !o_irq
  ) else $error("Interrupt raised with no enabled source pending.");

  a_flag_set_wins: assert property (
    seen_r |-> ((evt_stat & $past(evt_set)) == $past(evt_set))
  ) else $error("Flag event lost against a clear.");

  a_stat_no_set: assert property (
    (i_bus.wr && i_bus.addr == uig_pkg::BUS_EVENT_STATUS_OFS)
      |=> (evt_stat & ~$past(evt_stat | evt_set)) == 7'h00
  ) else $error("Status write set a flag.");

  a_bus_gate_shut: assert property (
    (!state_r.top_en[uig_pkg::TOP_BUS_EVT_BIT] && (top_pend[7:1] & state_r.top_en[7:1]) == 7'h00)
      |=> !o_irq
  ) else $error("Disabled bus events raised the interrupt.");

  a_ep_gate_shut: assert property (
    (state_r.top_en[7:2] == 6'h00 && (top_pend[1:0] & state_r.top_en[1:0]) == 2'h0)
      |=> !o_irq
  ) else $error("Disabled endpoints raised the interrupt.");

  a_ctrl_gate_shut: assert property (
    (!state_r.top_en[uig_pkg::TOP_CTRL_EP_BIT] && (top_pend & state_r.top_en & 8'hfd) == 8'h00)
      |=> !o_irq
  ) else $error("Disabled control endpoint raised the interrupt.");

  for (genvar g = 0; g < uig_pkg::EVT_NUM; g++)
  begin : g_evt_chk
    a_evt_own_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (evt_stat[g] && state_r.evt_en[g]) |-> top_pend[uig_pkg::TOP_BUS_EVT_BIT]
    ) else $error("Enabled event flag did not reach the bus-event source.");

    a_evt_own_mask: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (evt_stat == 7'(1 << g) && !state_r.evt_en[g]) |-> !top_pend[uig_pkg::TOP_BUS_EVT_BIT]
    ) else $error("Masked event flag reached the bus-event source.");
  end

  c_irq_rise: cover property ($rose(o_irq));

  c_suspend_clear: cover property (evt_stat[3] ##1 !evt_stat[3]);

  c_top_read: cover property (i_bus.rd && i_bus.addr == uig_pkg::TOP_IRQ_OFS);

  c_set_beats_clear: cover property (|(evt_set & evt_clr));

  c_usable_flag: cover property ($rose(evt_stat[uig_pkg::CLK_USABLE_BIT]));

endmodule

// ### uig_host_model.sv
// Purpose: Behavioural host and transceiver side that raises bus event pulses.
// Assumes: Requests come from the bench on i_clk.
// Notes: A pulse follows a request after i_wait idle cycles, so answers come prompt or slow.
`timescale 1ns/100ps
module uig_host_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [2:0] i_kind,
  input wire logic [3:0] i_wait,
  input wire logic i_clk_on,
  output uig_pkg::uig_evt_t o_evt,
  output logic o_clk_usable
);
  logic arm_r;
  logic [2:0] kind_r;
  logic [3:0] cnt_r;

  // The usable-clock level arrives with no relation to the block's clock edge.
  assign #13 o_clk_usable = i_clk_on;

  ////////////////////////////////////////////////////////////////////////////
  // One event pulse per request of kind 0 to 5, one clock long; kinds 6 and 7 give none.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      arm_r <= 1'b0;
      kind_r <= 3'h0;
      cnt_r <= 4'h0;
      o_evt <= '0;
    end
    else
    begin
      if (i_go)
      begin
        arm_r <= 1'b1;
        kind_r <= i_kind;
        cnt_r <= i_wait;
        o_evt <= '0;
      end
      else if (arm_r && cnt_r == 4'h0)
      begin
        arm_r <= 1'b0;
        o_evt <= uig_pkg::uig_evt_t'(6'h01 << kind_r);
      end
      else
      begin
        o_evt <= '0;
        if (arm_r)
        begin
          cnt_r <= cnt_r - 4'h1;
        end
      end
    end
  end
endmodule

// ### tb_uig_irq_gate.sv
// Purpose: Self-checking bench for the interrupt gating block.
// Assumes: Reads are checked by a monitor against notes queued by the driver.
// Notes: Each note holds the expected interrupt level above the read word.
`timescale 1ns/100ps
module tb_uig_irq_gate;
  localparam logic [31:0] A_TOP = uig_pkg::TOP_IRQ_OFS;
  localparam logic [31:0] A_TEN = uig_pkg::TOP_IRQ_ENABLE_OFS;
  localparam logic [31:0] A_ST = uig_pkg::BUS_EVENT_STATUS_OFS;
  localparam logic [31:0] A_EN = uig_pkg::BUS_EVENT_ENABLE_OFS;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic ctrl = 1'b0;
  logic clk_on = 1'b0;
  logic go = 1'b0;
  logic rd_d = 1'b0;
  logic usable;
  logic o_irq;
  uig_pkg::uig_bus_req_t bus = '0;
  uig_pkg::uig_evt_t evt;
  logic [5:0] ep = '0;
  logic [2:0] kind = '0;
  logic [3:0] wt = '0;
  logic [31:0] o_rdata;
  logic [7:0] m_top;
  logic [6:0] m_en;
  logic [6:0] m_st;
  logic [32:0] expq[$];
  logic [32:0] e;
  integer seed = 32'h541da77d;
  int n_errors = 0;
  int samples_checked = 0;

  uig_irq_gate u_uig_irq_gate (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .i_ep_pend(ep),
    .i_ctrl_ep_pend(ctrl), .i_clk_usable(usable), .i_evt(evt), .o_rdata(o_rdata), .o_irq(o_irq));
  uig_host_model u_uig_host_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go), .i_kind(kind),
    .i_wait(wt), .i_clk_on(clk_on), .o_evt(evt), .o_clk_usable(usable));

  initial
  begin
    forever #25 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expected interrupt level and read word.
  function automatic logic [32:0] exp_of(input logic [31:0] a);
    logic [7:0] p;
    logic [31:0] d;
    p = {ep, ctrl, |(m_st & m_en)};
    d = '0;
    if (a == A_TOP) d[7:0] = p;
    if (a == A_TEN) d[7:0] = m_top;
    if (a == A_ST) d[6:0] = m_st;
    if (a == A_EN) d[6:0] = m_en;
    return {|(p & m_top), d};
  endfunction

  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    if (!w) expq.push_back(exp_of(a));
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge i_clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    if (w && a == A_TEN) m_top = d[7:0];
    if (w && a == A_EN) m_en = d[6:0];
    if (w && a == A_ST) m_st = m_st & ~d[6:0];
    @(posedge i_clk);
  endtask

  task automatic pulse(input int k, input logic [3:0] w);
    kind <= 3'(k);
    wt <= w;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (w + 4) @(posedge i_clk);
    m_st[k] = 1'b1;
  endtask

  task automatic rst_seq;
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    m_top = 8'h01;
    m_en = 7'h40;
    m_st = 7'h08;
    @(posedge i_clk);
    acc(0, A_TEN, 0);
    acc(0, A_ST, 0);
    acc(0, A_EN, 0);
    acc(0, A_TOP, 0);
    acc(0, 32'hb000_600c, 0);
    $display("test reset values done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: each read answer is taken against the oldest note.
  always @(posedge i_clk) rd_d <= bus.rd;

  always @(negedge i_clk)
  begin
    if (rd_d === 1'b1)
    begin
      e = expq.pop_front();
      samples_checked++;
      if ({o_irq, o_rdata} !== e)
      begin
        n_errors++;
        $display("[FAIL] %0t got %h expected %h", $time, {o_irq, o_rdata}, e);
      end
    end
  end

  initial
  begin
    repeat (4000) @(posedge i_clk);
    n_errors++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    rst_seq();
    acc(1, A_ST, 32'hffff_fff7);
    acc(0, A_ST, 0);
    acc(1, A_ST, 32'h8);
    acc(0, A_ST, 0);
    $display("test suspend clear done");
    for (int k = 0; k < 6; k++)
    begin
      acc(1, A_EN, 32'(1 << k));
      pulse(k, 4'($random(seed)));
      acc(0, A_ST, 0);
      acc(1, A_EN, 32'(7'h7f ^ (1 << k)));
      acc(0, A_TOP, 0);
      acc(1, A_ST, 32'(1 << k));
      acc(0, A_ST, 0);
    end
    $display("test bus events done");
    acc(1, A_EN, 32'h40);
    clk_on <= 1'b1;
    repeat (6) @(posedge i_clk);
    m_st[6] = 1'b1;
    acc(0, A_TOP, 0);
    acc(0, A_ST, 0);
    acc(1, A_TEN, 0);
    acc(0, A_TOP, 0);
    acc(1, A_ST, 32'h40);
    clk_on <= 1'b0;
    $display("test usable clock done");
    for (int i = 0; i < 24; i++)
    begin
      ep <= 6'($random(seed));
      ctrl <= 1'($random(seed));
      acc(1, A_TEN, 32'($random(seed)));
      acc(0, A_TOP, 0);
      acc(0, A_TEN, 0);
    end
    acc(1, A_TOP, 32'hff);
    acc(1, 32'hb000_6004, 32'hff);
    acc(0, A_TOP, 0);
    acc(0, 32'hb000_6004, 0);
    $display("test endpoint gating done");
    rst_seq();
    repeat (2) @(posedge i_clk);
    end_sim();
  end
endmodule
